//--- design/dscg_defines.svh
`ifndef DSCG_DEFINES_SVH
`define DSCG_DEFINES_SVH

// ==========================================================================
// Register addresses and field positions.
`define DSCG_SCC_ADDR          12'hfb7
`define DSCG_SCC_SRC_BIT       0
`define DSCG_SCC_STOP_BIT      3
`define DSCG_PCC_SEL_LSB       0
`define DSCG_PCC_SEL_MSB       1
`define DSCG_PCC_HALT_BIT      2
`define DSCG_PCC_STOP_BIT      3

// ==========================================================================
// Reset values.
`define DSCG_PCC_RESET         4'h0
`define DSCG_SCC_RESET         4'h0

// ==========================================================================
// Oscillator ticks per machine cycle.
`define DSCG_DIV_SEL0          7'h40
`define DSCG_DIV_SEL1          7'h10
`define DSCG_DIV_SEL2          7'h08
`define DSCG_DIV_SEL3          7'h04
`define DSCG_DIV_SUB           7'h04

// ==========================================================================
// Switch-over delays in machine cycles of the old setting.
`define DSCG_DLY_SEL0          5'h01
`define DSCG_DLY_SEL1          5'h04
`define DSCG_DLY_SEL2          5'h08
`define DSCG_DLY_SEL3          5'h10
`define DSCG_DLY_FROM_SUB      5'h01

// ==========================================================================
// Timing.
`define DSCG_STAB_WAIT_NS      21800000
`define DSCG_CLK_PERIOD_NS     10

// ==========================================================================
// Peripheral divider taps, divide by 8 up to 4096.
`define DSCG_PERIPH_FIRST_TAP  3
`define DSCG_PERIPH_TAPS       10
`define DSCG_PERIPH_WIDTH      12

`endif

//--- design/dscg_pkg.sv
package dscg_pkg;

  // ========================================================================
  // Types.
  typedef logic [3:0] dscg_nib_t;
  typedef logic [1:0] dscg_sel_t;

  typedef enum logic [1:0] {
    ST_STAB    = 2'b00,
    ST_RUN     = 2'b01,
    ST_TO_MAIN = 2'b10,
    ST_TO_SUB  = 2'b11
  } dscg_state_e;

endpackage : dscg_pkg

//--- design/dscg_divider.sv
`timescale 1ns/1ps
`include "dscg_defines.svh"

module dscg_divider #(
  parameter int unsigned WIDTH     = `DSCG_PERIPH_WIDTH,
  parameter int unsigned FIRST_TAP = `DSCG_PERIPH_FIRST_TAP,
  parameter int unsigned NUM_TAPS  = `DSCG_PERIPH_TAPS
) (
  // Clock and reset.
  input  wire logic                ref_clk_in,
  input  wire logic                reset_in,
  // Source tick.
  input  wire logic                tick_in,
  // Divided ticks.
  output logic      [NUM_TAPS-1:0] tap_tick_out
);

  logic [WIDTH-1:0]    cnt_q;
  logic [WIDTH-1:0]    cnt_d;
  logic [NUM_TAPS-1:0] tap_q;
  logic [NUM_TAPS-1:0] tap_d;

  // ========================================================================
  // Free-running prescaler.
  always_comb begin
    cnt_d = cnt_q;
    if (tick_in) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // ========================================================================
  // One pulse per tap when its low bits roll over.
  for (genvar i = 0; i < NUM_TAPS; i++) begin : g_tap
    assign tap_d[i] = tick_in & (&cnt_q[FIRST_TAP+i-1:0]);
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      cnt_q <= '0;
      tap_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      tap_q <= tap_d;
    end
  end

  assign tap_tick_out = tap_q;

endmodule : dscg_divider

//--- design/dscg_clock_gen.sv
`timescale 1ns/1ps
`include "dscg_defines.svh"

module dscg_clock_gen #(
  parameter int unsigned STAB_WAIT_CYCLES =
    (`DSCG_STAB_WAIT_NS + `DSCG_CLK_PERIOD_NS - 1) / `DSCG_CLK_PERIOD_NS
) (
  // Clock and reset.
  input  wire logic               ref_clk_in,
  input  wire logic               reset_in,
  // Oscillator pins.
  input  wire logic               main_osc_in,
  input  wire logic               sub_osc_in,
  output logic                    main_osc_enable_out,
  output logic                    main_osc_ground_out,
  // Processor clock register access.
  input  wire logic               pcc_wr_in,
  input  wire dscg_pkg::dscg_nib_t pcc_wdata_in,
  output dscg_pkg::dscg_nib_t     pcc_rdata_out,
  // System clock register bit access.
  input  wire logic               scc_bit_wr_in,
  input  wire logic        [11:0] scc_addr_in,
  input  wire dscg_pkg::dscg_sel_t scc_bit_sel_in,
  input  wire logic               scc_bit_val_in,
  output dscg_pkg::dscg_nib_t     scc_rdata_out,
  // Standby instructions and release.
  input  wire logic               stop_instr_in,
  input  wire logic               halt_instr_in,
  input  wire logic               standby_release_in,
  // CPU clock.
  output logic                    cpu_tick_out,
  output logic                    cpu_hold_out,
  output logic                    cpu_on_sub_out,
  output logic                    switch_busy_out,
  // Peripheral clocks.
  output logic              [9:0] periph_tick_out,
  output logic                    watch_sub_tick_out
);

  import dscg_pkg::*;

  // ========================================================================
  // Oscillator pin synchronisers and edge detection.
  logic [1:0] pin_raw;
  logic [1:0] pin_tick;

  assign pin_raw = {sub_osc_in, main_osc_in};

  for (genvar g = 0; g < 2; g++) begin : g_pin
    logic s1_q;
    logic s1_d;
    logic s2_q;
    logic s2_d;
    logic s3_q;
    logic s3_d;
    logic filt_q;
    logic filt_d;
    logic prev_q;
    logic prev_d;

    always_comb begin
      s1_d   = pin_raw[g];
      s2_d   = s1_q;
      s3_d   = s2_q;
      filt_d = (s2_q == s3_q) ? s3_q : filt_q;
      prev_d = filt_q;
    end

    always_ff @(posedge ref_clk_in) begin
      if (reset_in) begin
        s1_q   <= 1'b0;
        s2_q   <= 1'b0;
        s3_q   <= 1'b0;
        filt_q <= 1'b0;
        prev_q <= 1'b0;
      end else begin
        s1_q   <= s1_d;
        s2_q   <= s2_d;
        s3_q   <= s3_d;
        filt_q <= filt_d;
        prev_q <= prev_d;
      end
    end

    assign pin_tick[g] = filt_q & ~prev_q;
  end

  logic main_osc_en_q;
  logic main_osc_en_d;
  logic main_tick;
  logic sub_tick;

  assign main_tick = pin_tick[0] & main_osc_en_q;
  assign sub_tick  = pin_tick[1];

  // ========================================================================
  // Control registers.
  dscg_nib_t   pcc_q;
  dscg_nib_t   pcc_d;
  dscg_nib_t   scc_q;
  dscg_nib_t   scc_d;
  logic        act_sub_q;
  logic        scc_hit;

  assign scc_hit = scc_bit_wr_in && (scc_addr_in == `DSCG_SCC_ADDR);

  always_comb begin
    pcc_d = pcc_q;
    scc_d = scc_q;
    if (pcc_wr_in) begin
      pcc_d = {2'b00, pcc_wdata_in[`DSCG_PCC_SEL_MSB:`DSCG_PCC_SEL_LSB]};
    end
    if (standby_release_in) begin
      pcc_d[`DSCG_PCC_STOP_BIT] = 1'b0;
      pcc_d[`DSCG_PCC_HALT_BIT] = 1'b0;
    end
    if (halt_instr_in) begin
      pcc_d[`DSCG_PCC_HALT_BIT] = 1'b1;
    end
    if (stop_instr_in && !act_sub_q) begin
      pcc_d[`DSCG_PCC_STOP_BIT] = 1'b1;
    end
    if (scc_hit) begin
      case (scc_bit_sel_in)
        2'h0: begin
          if (scc_bit_val_in || !scc_q[`DSCG_SCC_STOP_BIT]) begin
            scc_d[`DSCG_SCC_SRC_BIT] = scc_bit_val_in;
          end
        end
        2'h3: begin
          if (!scc_bit_val_in || scc_q[`DSCG_SCC_SRC_BIT]) begin
            scc_d[`DSCG_SCC_STOP_BIT] = scc_bit_val_in;
          end
        end
        default: begin
          scc_d = scc_q;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      pcc_q <= `DSCG_PCC_RESET;
      scc_q <= `DSCG_SCC_RESET;
    end else begin
      pcc_q <= pcc_d;
      scc_q <= scc_d;
    end
  end

  reset_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    $fell(reset_in) |-> (pcc_q == 4'h0) && (scc_q == 4'h0))
    else $error("control registers not cleared by reset");

  pcc_write_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    pcc_wr_in && !halt_instr_in && !stop_instr_in |=>
      (pcc_q[3:2] == 2'b00) && (pcc_q[1:0] == $past(pcc_wdata_in[1:0])))
    else $error("processor clock write stored wrong value");

  release_clear_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    standby_release_in && !halt_instr_in && !stop_instr_in |=> (pcc_q[3:2] == 2'b00))
    else $error("standby release did not clear stop and halt");

  stop_main_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    stop_instr_in && act_sub_q && !pcc_q[3] |=> !pcc_q[3])
    else $error("stop accepted while on subsystem clock");

  bad_combo_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    !(scc_q[3] && !scc_q[0]))
    else $error("system clock register holds forbidden value");

  // ========================================================================
  // Source selection, switch-over and CPU clock.
  dscg_state_e state_q;
  dscg_state_e state_d;
  dscg_sel_t   act_sel_q;
  dscg_sel_t   act_sel_d;
  logic        act_sub_d;
  logic  [4:0] switch_cnt_q;
  logic  [4:0] switch_cnt_d;
  logic  [4:0] target_q;
  logic  [4:0] target_d;
  logic [21:0] stab_cnt_q;
  logic [21:0] stab_cnt_d;
  logic  [6:0] cpu_cnt_q;
  logic  [6:0] cpu_cnt_d;
  logic        cpu_tick_q;
  logic        cpu_tick_d;
  logic        watch_tick_q;
  logic        apply;
  logic        src_tick;
  logic        mc_tick;
  logic  [6:0] div_lim;

  function automatic logic [6:0] div_of(input logic sub, input dscg_sel_t sel);
    logic [6:0] lim;
    lim = `DSCG_DIV_SUB;
    if (!sub) begin
      case (sel)
        2'h0:    lim = `DSCG_DIV_SEL0;
        2'h1:    lim = `DSCG_DIV_SEL1;
        2'h2:    lim = `DSCG_DIV_SEL2;
        default: lim = `DSCG_DIV_SEL3;
      endcase
    end
    return lim;
  endfunction : div_of

  function automatic logic [4:0] dly_of(input dscg_sel_t sel);
    logic [4:0] dly;
    case (sel)
      2'h0:    dly = `DSCG_DLY_SEL0;
      2'h1:    dly = `DSCG_DLY_SEL1;
      2'h2:    dly = `DSCG_DLY_SEL2;
      default: dly = `DSCG_DLY_SEL3;
    endcase
    return dly;
  endfunction : dly_of

  assign div_lim  = div_of(act_sub_q, act_sel_q);
  assign src_tick = act_sub_q ? sub_tick : main_tick;
  assign mc_tick  = src_tick && (cpu_cnt_q == div_lim - 7'h01);

  always_comb begin
    state_d      = state_q;
    act_sel_d    = act_sel_q;
    act_sub_d    = act_sub_q;
    switch_cnt_d = switch_cnt_q;
    target_d     = target_q;
    stab_cnt_d   = stab_cnt_q;
    apply        = 1'b0;
    case (state_q)
      ST_STAB: begin
        stab_cnt_d = stab_cnt_q + 22'h00_0001;
        if (stab_cnt_q == 22'(STAB_WAIT_CYCLES - 1)) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (scc_q[`DSCG_SCC_SRC_BIT] && !act_sub_q) begin
          state_d = ST_TO_SUB;
        end else if (!scc_q[`DSCG_SCC_SRC_BIT] && act_sub_q) begin
          target_d     = `DSCG_DLY_FROM_SUB;
          switch_cnt_d = 5'h00;
          state_d      = ST_TO_MAIN;
        end else if (!act_sub_q && (pcc_q[1:0] != act_sel_q)) begin
          target_d     = dly_of(act_sel_q);
          switch_cnt_d = 5'h00;
          state_d      = ST_TO_MAIN;
        end
      end
      ST_TO_MAIN: begin
        if (mc_tick) begin
          if (switch_cnt_q == target_q - 5'h01) begin
            apply     = 1'b1;
            act_sel_d = pcc_q[1:0];
            act_sub_d = 1'b0;
            state_d   = ST_RUN;
          end else begin
            switch_cnt_d = switch_cnt_q + 5'h01;
          end
        end
      end
      ST_TO_SUB: begin
        if (!scc_q[`DSCG_SCC_SRC_BIT]) begin
          state_d = ST_RUN;
        end else if (sub_tick) begin
          apply     = 1'b1;
          act_sub_d = 1'b1;
          state_d   = ST_RUN;
        end
      end
      default: begin
        state_d = ST_STAB;
      end
    endcase
  end

  always_comb begin
    cpu_cnt_d = cpu_cnt_q;
    if (apply) begin
      cpu_cnt_d = 7'h00;
    end else if (src_tick) begin
      cpu_cnt_d = mc_tick ? 7'h00 : cpu_cnt_q + 7'h01;
    end
    cpu_tick_d = mc_tick && (state_q != ST_STAB) && !pcc_q[`DSCG_PCC_HALT_BIT] &&
                 !pcc_q[`DSCG_PCC_STOP_BIT];
    main_osc_en_d = !pcc_q[`DSCG_PCC_STOP_BIT] &&
                    !(scc_q[`DSCG_SCC_STOP_BIT] && act_sub_q);
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state_q       <= ST_STAB;
      act_sel_q     <= 2'h0;
      act_sub_q     <= 1'b0;
      switch_cnt_q  <= 5'h00;
      target_q      <= 5'h01;
      stab_cnt_q    <= 22'h00_0000;
      cpu_cnt_q     <= 7'h00;
      cpu_tick_q    <= 1'b0;
      main_osc_en_q <= 1'b1;
      watch_tick_q  <= 1'b0;
    end else begin
      state_q       <= state_d;
      act_sel_q     <= act_sel_d;
      act_sub_q     <= act_sub_d;
      switch_cnt_q  <= switch_cnt_d;
      target_q      <= target_d;
      stab_cnt_q    <= stab_cnt_d;
      cpu_cnt_q     <= cpu_cnt_d;
      cpu_tick_q    <= cpu_tick_d;
      main_osc_en_q <= main_osc_en_d;
      watch_tick_q  <= sub_tick;
    end
  end

  stab_hold_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (state_q == ST_STAB) |=> !cpu_tick_q)
    else $error("CPU clocked during stabilization wait");

  sub_div_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    act_sub_q |-> (cpu_cnt_q <= 7'h03))
    else $error("subsystem prescaler exceeds divide by four");

  switch_cnt_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (state_q == ST_TO_MAIN) |-> (switch_cnt_q < target_q) && (target_q <= 5'h10))
    else $error("switch-over counter out of range");

  old_clock_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    (state_q == ST_TO_MAIN) && !mc_tick |=> $stable(act_sel_q) && $stable(act_sub_q))
    else $error("clock changed before switch-over delay");

  halt_gate_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    pcc_q[`DSCG_PCC_HALT_BIT] |=> !cpu_tick_q)
    else $error("CPU clocked while halted");

  osc_stop_main_a: assert property (@(posedge ref_clk_in) disable iff (reset_in)
    scc_q[3] && !act_sub_q && !pcc_q[3] |=> main_osc_enable_out)
    else $error("main oscillator stopped while it drives the CPU");

  // ========================================================================
  // Peripheral clock divider.
  dscg_divider #(
    .WIDTH     (`DSCG_PERIPH_WIDTH),
    .FIRST_TAP (`DSCG_PERIPH_FIRST_TAP),
    .NUM_TAPS  (`DSCG_PERIPH_TAPS)
  ) u_periph_div (
    .ref_clk_in   (ref_clk_in),
    .reset_in     (reset_in),
    .tick_in      (main_tick),
    .tap_tick_out (periph_tick_out)
  );

  // ========================================================================
  // Outputs.
  assign main_osc_enable_out = main_osc_en_q;
  assign main_osc_ground_out = scc_q[`DSCG_SCC_STOP_BIT];
  assign pcc_rdata_out       = pcc_q;
  assign scc_rdata_out       = scc_q;
  assign cpu_tick_out        = cpu_tick_q;
  assign cpu_hold_out        = (state_q == ST_STAB);
  assign cpu_on_sub_out      = act_sub_q;
  assign switch_busy_out     = (state_q == ST_TO_MAIN) || (state_q == ST_TO_SUB);
  assign watch_sub_tick_out  = watch_tick_q;

endmodule : dscg_clock_gen

//--- verification/dscg_clock_gen_bench.sv
`timescale 1ns/1ps
`define DSCG_CHECK(what, exp, got) \
  begin \
    samples_checked++; \
    if ((exp) !== (got)) begin \
      num_errors++; \
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module dscg_clock_gen_bench;
  import dscg_pkg::*;

  // ==========================================================================
  // Signals.
  localparam int unsigned STAB = 20;
  localparam int DIVS [4] = '{64, 16, 8, 4};
  localparam int DLYS [4] = '{1, 4, 8, 16};
  logic        ref_clk_in;
  logic        reset_in;
  logic        main_osc_in;
  logic        sub_osc_in;
  logic        main_osc_enable_out;
  logic        main_osc_ground_out;
  logic        pcc_wr_in;
  dscg_nib_t   pcc_wdata_in;
  dscg_nib_t   pcc_rdata_out;
  logic        scc_bit_wr_in;
  logic [11:0] scc_addr_in;
  dscg_sel_t   scc_bit_sel_in;
  logic        scc_bit_val_in;
  dscg_nib_t   scc_rdata_out;
  logic        stop_instr_in;
  logic        halt_instr_in;
  logic        standby_release_in;
  logic        cpu_tick_out;
  logic        cpu_hold_out;
  logic        cpu_on_sub_out;
  logic        switch_busy_out;
  logic [9:0]  periph_tick_out;
  logic        watch_sub_tick_out;
  int unsigned osc_cnt;
  int          num_errors;
  int          samples_checked;

  dscg_clock_gen #(.STAB_WAIT_CYCLES(STAB)) dscg_clock_gen_i (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .main_osc_in(main_osc_in), .sub_osc_in(sub_osc_in),
    .main_osc_enable_out(main_osc_enable_out), .main_osc_ground_out(main_osc_ground_out),
    .pcc_wr_in(pcc_wr_in), .pcc_wdata_in(pcc_wdata_in), .pcc_rdata_out(pcc_rdata_out),
    .scc_bit_wr_in(scc_bit_wr_in), .scc_addr_in(scc_addr_in),
    .scc_bit_sel_in(scc_bit_sel_in), .scc_bit_val_in(scc_bit_val_in),
    .scc_rdata_out(scc_rdata_out), .stop_instr_in(stop_instr_in),
    .halt_instr_in(halt_instr_in), .standby_release_in(standby_release_in),
    .cpu_tick_out(cpu_tick_out), .cpu_hold_out(cpu_hold_out),
    .cpu_on_sub_out(cpu_on_sub_out), .switch_busy_out(switch_busy_out),
    .periph_tick_out(periph_tick_out), .watch_sub_tick_out(watch_sub_tick_out));

  // ==========================================================================
  // Clock and oscillators: main period 8 cycles, sub period 40 cycles.
  always #5 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in) begin
    osc_cnt <= osc_cnt + 1;
    main_osc_in <= main_osc_enable_out && !main_osc_ground_out && osc_cnt[2];
    sub_osc_in <= (osc_cnt % 40) >= 20;
  end

  // ==========================================================================
  // Helpers.
  task automatic stop_test;
    $display("Comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test

  task automatic give_up;
    num_errors++;
    $display("Wait limit reached");
    stop_test();
  endtask : give_up

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = cpu_tick_out;
      1: pick = periph_tick_out[0];
      3: pick = periph_tick_out[1];
      default: pick = watch_sub_tick_out;
    endcase
  endfunction : pick

  task automatic pcc_write(input dscg_nib_t v);
    @(posedge ref_clk_in);
    pcc_wr_in <= 1'b1;
    pcc_wdata_in <= v;
    @(posedge ref_clk_in);
    pcc_wr_in <= 1'b0;
  endtask : pcc_write

  task automatic scc_write(input logic [11:0] a, input dscg_sel_t b, input logic v);
    @(posedge ref_clk_in);
    scc_bit_wr_in <= 1'b1;
    scc_addr_in <= a;
    scc_bit_sel_in <= b;
    scc_bit_val_in <= v;
    @(posedge ref_clk_in);
    scc_bit_wr_in <= 1'b0;
    repeat (2) @(negedge ref_clk_in);
  endtask : scc_write

  task automatic pulse(input int which);
    @(posedge ref_clk_in);
    stop_instr_in <= which == 0;
    halt_instr_in <= which == 1;
    standby_release_in <= which == 2;
    @(posedge ref_clk_in);
    {stop_instr_in, halt_instr_in, standby_release_in} <= 3'b000;
    repeat (2) @(negedge ref_clk_in);
  endtask : pulse

  task automatic count(input int sel, input int len, output int n);
    n = 0;
    repeat (len) begin
      @(negedge ref_clk_in);
      if (pick(sel) === 1'b1) n++;
    end
  endtask : count

  task automatic gap(input int sel, output int n);
    int c;
    c = 0;
    n = 1;
    while (pick(sel) !== 1'b1 && c < 2000) begin
      @(negedge ref_clk_in);
      c++;
    end
    @(negedge ref_clk_in);
    while (pick(sel) !== 1'b1 && n < 2000) begin
      @(negedge ref_clk_in);
      n++;
    end
    if (c >= 2000 || n >= 2000) give_up();
  endtask : gap

  task automatic settle(output int t);
    int c;
    t = 0;
    c = 0;
    while ((c < 3 || switch_busy_out === 1'b1) && c < 20000) begin
      @(negedge ref_clk_in);
      if (cpu_tick_out === 1'b1) t++;
      c++;
    end
    if (c >= 20000) give_up();
  endtask : settle

  // ==========================================================================
  // Scenarios.
  task automatic t_reset;
    int n;
    n = 0;
    `DSCG_CHECK("pcc reset", 4'h0, pcc_rdata_out)
    `DSCG_CHECK("scc reset", 4'h0, scc_rdata_out)
    while (cpu_hold_out === 1'b1 && n < STAB + 10) begin
      `DSCG_CHECK("tick in hold", 1'b0, cpu_tick_out)
      @(negedge ref_clk_in);
      n++;
    end
    `DSCG_CHECK("hold length", 1'b1, n >= STAB - 2 && n <= STAB + 3)
    gap(0, n);
    `DSCG_CHECK("slowest period", 8 * DIVS[0], n)
    gap(1, n);
    `DSCG_CHECK("periph period", 64, n)
    gap(3, n);
    `DSCG_CHECK("periph tap two", 128, n)
    $display("Test reset done");
  endtask : t_reset

  task automatic t_rates;
    int n;
    int k;
    int s;
    int old;
    old = 0;
    for (k = 0; k < 4; k++) begin
      s = 3 - k;
      pcc_write(4'hc | 4'(s));
      settle(n);
      `DSCG_CHECK("switch ticks", 1'b1, n >= DLYS[old] - 1 && n <= DLYS[old])
      `DSCG_CHECK("pcc value", 4'(s), pcc_rdata_out)
      gap(0, n);
      `DSCG_CHECK("cpu period", 8 * DIVS[s], n)
      old = s;
    end
    $display("Test rates done");
  endtask : t_rates

  task automatic t_standby;
    int n;
    pulse(1);
    `DSCG_CHECK("halt bit", 4'h6, pcc_rdata_out)
    count(0, 300, n);
    `DSCG_CHECK("ticks in halt", 0, n)
    `DSCG_CHECK("osc in halt", 1'b1, main_osc_enable_out)
    count(1, 200, n);
    `DSCG_CHECK("periph in halt", 3, n)
    pulse(2);
    `DSCG_CHECK("halt cleared", 4'h2, pcc_rdata_out)
    gap(0, n);
    `DSCG_CHECK("resumed period", 8 * DIVS[2], n)
    pulse(0);
    `DSCG_CHECK("stop bit", 4'ha, pcc_rdata_out)
    `DSCG_CHECK("osc stopped", 1'b0, main_osc_enable_out)
    count(0, 300, n);
    `DSCG_CHECK("ticks in stop", 0, n)
    pulse(2);
    `DSCG_CHECK("stop cleared", 4'h2, pcc_rdata_out)
    `DSCG_CHECK("osc restarted", 1'b1, main_osc_enable_out)
    $display("Test standby done");
  endtask : t_standby

  task automatic t_sub;
    int n;
    scc_write(12'hfb7, 2'd3, 1'b1);
    `DSCG_CHECK("stop refused", 4'h0, scc_rdata_out)
    `DSCG_CHECK("osc on main", 1'b1, main_osc_enable_out)
    scc_write(12'hfb6, 2'd0, 1'b1);
    `DSCG_CHECK("other address", 4'h0, scc_rdata_out)
    scc_write(12'hfb7, 2'd0, 1'b1);
    `DSCG_CHECK("source bit", 4'h1, scc_rdata_out)
    `DSCG_CHECK("switch busy", 1'b1, switch_busy_out)
    n = 0;
    while (cpu_on_sub_out !== 1'b1 && n < 200) begin
      @(negedge ref_clk_in);
      n++;
    end
    `DSCG_CHECK("to sub time", 1'b1, n <= 45)
    gap(0, n);
    `DSCG_CHECK("sub period", 160, n)
    pcc_write(4'h3);
    settle(n);
    gap(0, n);
    `DSCG_CHECK("select ignored", 160, n)
    pulse(0);
    `DSCG_CHECK("stop on sub", 4'h3, pcc_rdata_out)
    pulse(1);
    `DSCG_CHECK("halt on sub", 4'h7, pcc_rdata_out)
    pulse(2);
    repeat (5200) @(negedge ref_clk_in);
    scc_write(12'hfb7, 2'd3, 1'b1);
    repeat (2) @(negedge ref_clk_in);
    `DSCG_CHECK("scc stopped", 4'h9, scc_rdata_out)
    `DSCG_CHECK("osc off", 1'b0, main_osc_enable_out)
    `DSCG_CHECK("input grounded", 1'b1, main_osc_ground_out)
    count(1, 300, n);
    `DSCG_CHECK("periph idle", 0, n)
    gap(2, n);
    `DSCG_CHECK("watch period", 40, n)
    scc_write(12'hfb7, 2'd0, 1'b0);
    `DSCG_CHECK("clear refused", 4'h9, scc_rdata_out)
    scc_write(12'hfb7, 2'd3, 1'b0);
    `DSCG_CHECK("osc bit clear", 4'h1, scc_rdata_out)
    `DSCG_CHECK("ground off", 1'b0, main_osc_ground_out)
    repeat (100) @(negedge ref_clk_in);
    scc_write(12'hfb7, 2'd0, 1'b0);
    settle(n);
    `DSCG_CHECK("back ticks", 1'b1, n <= 1)
    `DSCG_CHECK("on main", 1'b0, cpu_on_sub_out)
    gap(0, n);
    `DSCG_CHECK("main period", 8 * DIVS[3], n)
    $display("Test subsystem done");
  endtask : t_sub

  // ==========================================================================
  // Main sequence.
  initial begin
    int n;
    ref_clk_in = 1'b0;
    reset_in = 1'b1;
    osc_cnt = 0;
    main_osc_in = 1'b0;
    sub_osc_in = 1'b0;
    pcc_wr_in = 1'b0;
    pcc_wdata_in = 4'h0;
    scc_bit_wr_in = 1'b0;
    scc_addr_in = 12'h000;
    scc_bit_sel_in = 2'd0;
    scc_bit_val_in = 1'b0;
    {stop_instr_in, halt_instr_in, standby_release_in} = 3'b000;
    num_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge ref_clk_in);
    reset_in <= 1'b0;
    @(negedge ref_clk_in);
    t_reset();
    t_rates();
    pcc_write(4'h2);
    settle(n);
    t_standby();
    t_sub();
    stop_test();
  end
endmodule : dscg_clock_gen_bench
